/* File: src/sfspi_front_end.sv */
module sfspi_front_end (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic hold_n,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   input wire logic write_protect_supply,
   input wire logic busy,
   input wire logic [sfspi_pkg::BYTE_W-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output sfspi_pkg::sfspi_rx_t rx,
   output logic rx_valid,
   output logic frame_start,
   output logic frame_end,
   output logic frame_ok,
   output sfspi_pkg::sfspi_addr_t addr,
   output logic [sfspi_pkg::DATA_CNT_W-1:0] data_cnt,
   output sfspi_pkg::sfspi_phase_t phase,
   output logic selected,
   output logic active,
   output logic paused,
   output logic fast_mode,
   output logic armed
);
   import sfspi_pkg::*;
   // ----------------------------------------------------------------
   // link side, on the serial clock
   // ----------------------------------------------------------------

   // link counters restart whenever select is high
   logic link_rst_n;
   logic [BITCNT_W-1:0] bit_cnt_r;
   logic [BITCNT_W-1:0] bit_cnt_nxt;
   logic [BYTE_W-1:0] in_sh_r;
   logic [BYTE_W-1:0] in_byte_nxt;
   logic [BYTE_W-1:0] rx_byte_r;
   logic rx_tgl_r;
   logic partial_r;
   logic [BYTE_W-1:0] out_sh_r;
   logic [BYTE_W-1:0] tx_hold_r;
   logic byte_done;
   assign link_rst_n = resetn & ~cs_n;
   assign bit_cnt_nxt = bit_cnt_r + BIT_STEP;
   assign in_byte_nxt = {in_sh_r[BYTE_W-2:0], sdi};
   assign byte_done = hold_n & (bit_cnt_r == BIT_LAST);
   // input shift on rising edges, frozen while paused
   always_ff @(posedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         bit_cnt_r <= BIT_FIRST;
         in_sh_r <= '0;
      end else if (hold_n) begin
         bit_cnt_r <= bit_cnt_nxt;
         in_sh_r <= in_byte_nxt;
      end
   end

   // completed byte and its event toggle survive deselection
   always_ff @(posedge sclk or negedge resetn) begin
      if (!resetn) begin
         rx_byte_r <= '0;
         rx_tgl_r <= 1'b0;
         partial_r <= 1'b0;
      end else if (hold_n) begin
         partial_r <= (bit_cnt_nxt != BIT_FIRST);
         if (byte_done) begin
            rx_byte_r <= in_byte_nxt;
            rx_tgl_r <= ~rx_tgl_r;
         end
      end
   end

   // output shift on falling edges; a new byte loads at each byte boundary
   always_ff @(negedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         out_sh_r <= '0;
      end else if (hold_n) begin
         if (bit_cnt_r == BIT_FIRST) begin
            out_sh_r <= tx_hold_r;
         end else begin
            out_sh_r <= {out_sh_r[BYTE_W-2:0], 1'b0};
         end
      end
   end

   // serial output floats when deselected or paused
   assign sdo = out_sh_r[BYTE_W-1];
   assign sdo_oe = ~cs_n & hold_n;

   // ----------------------------------------------------------------
   // crossing into the system clock domain
   // ----------------------------------------------------------------
   logic [NSYNC-1:0] sync_in;
   logic [NSYNC-1:0] s1_r;
   logic [NSYNC-1:0] s2_r;
   logic cs_d_r;
   logic tgl_d_r;

   assign sync_in[SY_CS] = cs_n;
   assign sync_in[SY_HOLD] = hold_n;
   assign sync_in[SY_WPS] = write_protect_supply;
   assign sync_in[SY_TGL] = rx_tgl_r;
   assign sync_in[SY_PART] = partial_r;

   // two flip-flops per lane
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               s1_r[gi] <= SYNC_RST[gi];
               s2_r[gi] <= SYNC_RST[gi];
            end else if (ce) begin
               s1_r[gi] <= sync_in[gi];
               s2_r[gi] <= s1_r[gi];
            end
         end
      end
   endgenerate

   // edge history of the synchronised select and byte toggle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cs_d_r <= SYNC_RST[SY_CS];
         tgl_d_r <= 1'b0;
      end else if (ce) begin
         cs_d_r <= s2_r[SY_CS];
         tgl_d_r <= s2_r[SY_TGL];
      end
   end

   // ----------------------------------------------------------------
   // system side events and status
   // ----------------------------------------------------------------
   logic cs_fall;
   logic cs_rise;
   logic rx_ev;
   logic sel_now;
   logic armed_r;
   logic active_r;
   logic selected_r;
   logic paused_r;
   logic fast_r;
   logic frame_start_r;
   logic frame_end_r;
   logic frame_ok_r;
   logic rx_valid_r;
   sfspi_rx_t rx_r;
   logic tx_full_r;
   logic tx_take;
   assign cs_fall = cs_d_r & ~s2_r[SY_CS];
   assign cs_rise = ~cs_d_r & s2_r[SY_CS];
   assign rx_ev = s2_r[SY_TGL] ^ tgl_d_r;
   assign sel_now = ~s2_r[SY_CS];
   assign tx_take = tx_valid & ~tx_full_r;
   // arming by the first select falling edge after reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         armed_r <= 1'b0;
      end else if (ce && cs_fall) begin
         armed_r <= 1'b1;
      end
   end

   // power state and pin status
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         active_r <= 1'b0;
         selected_r <= 1'b0;
         paused_r <= 1'b0;
         fast_r <= 1'b0;
      end else if (ce) begin
         active_r <= sel_now | busy;
         selected_r <= sel_now;
         paused_r <= sel_now & ~s2_r[SY_HOLD];
         fast_r <= s2_r[SY_WPS];
      end
   end

   // frame boundaries and received bytes; frame end and bytes ignored until armed, a byte ended just before deselect still counts
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         frame_start_r <= 1'b0;
         frame_end_r <= 1'b0;
         frame_ok_r <= 1'b0;
         rx_valid_r <= 1'b0;
         rx_r <= '0;
      end else if (ce) begin
         frame_start_r <= cs_fall;
         frame_end_r <= cs_rise & armed_r;
         if (cs_rise) begin
            frame_ok_r <= ~s2_r[SY_PART];
         end
         rx_valid_r <= rx_ev & armed_r;
         if (rx_ev) begin
            rx_r.data <= rx_byte_r;
            rx_r.first <= (phase == PH_CMD);
         end
      end
   end

   // one-byte transmit slot, emptied when the link takes a byte boundary
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_full_r <= 1'b0;
         tx_hold_r <= '0;
      end else if (ce) begin
         if (tx_take) begin
            tx_full_r <= 1'b1;
            tx_hold_r <= tx_data;
         end else if (rx_ev) begin
            tx_full_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // frame phase: instruction, three address bytes, data bytes
   // ----------------------------------------------------------------
   sfspi_phase_t phase_r;
   sfspi_phase_t phase_nxt;
   sfspi_addr_t addr_r;
   logic [ADDR_CNT_W-1:0] addr_cnt_r;
   logic [DATA_CNT_W-1:0] data_cnt_r;
   logic byte_in;
   assign byte_in = rx_ev & armed_r;
   // next phase
   always_comb begin
      phase_nxt = phase_r;
      case (phase_r)
         PH_IDLE: begin
            phase_nxt = PH_IDLE;
         end
         PH_CMD: begin
            if (byte_in) phase_nxt = PH_ADDR;
         end
         PH_ADDR: begin
            if (byte_in && addr_cnt_r == ADDR_CNT_LAST) phase_nxt = PH_DATA;
         end
         PH_DATA: begin
            phase_nxt = PH_DATA;
         end
         default: begin
            phase_nxt = PH_IDLE;
         end
      endcase
      if (cs_rise) phase_nxt = PH_IDLE;
      if (cs_fall) phase_nxt = PH_CMD;
   end

   // phase, address assembly and data byte count
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         phase_r <= PH_IDLE;
         addr_r <= '0;
         addr_cnt_r <= '0;
         data_cnt_r <= DATA_CNT_ZERO;
      end else if (ce) begin
         phase_r <= phase_nxt;
         if (cs_fall) begin
            addr_cnt_r <= '0;
            data_cnt_r <= DATA_CNT_ZERO;
         end else if (byte_in && phase_r == PH_ADDR) begin
            addr_r <= {addr_r[ADDR_W-BYTE_W-1:0], rx_byte_r};
            addr_cnt_r <= addr_cnt_r + ADDR_CNT_ONE;
         end else if (byte_in && phase_r == PH_DATA && data_cnt_r != DATA_CNT_MAX) begin
            data_cnt_r <= data_cnt_r + DATA_CNT_ONE;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign tx_ready = ~tx_full_r;
   assign rx = rx_r;
   assign rx_valid = rx_valid_r;
   assign frame_start = frame_start_r;
   assign frame_end = frame_end_r;
   assign frame_ok = frame_ok_r;
   assign addr = addr_r;
   assign data_cnt = data_cnt_r;
   assign phase = phase_r;
   assign selected = selected_r;
   assign active = active_r;
   assign paused = paused_r;
   assign fast_mode = fast_r;
   assign armed = armed_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   deselect_float_a: assert property (@(posedge clk) disable iff (!resetn)
      cs_n |-> !sdo_oe) else $error("serial output driven while deselected");
   pause_float_a: assert property (@(posedge clk) disable iff (!resetn)
      !hold_n |-> !sdo_oe) else $error("serial output driven while paused");
   select_active_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && !s2_r[SY_CS] |=> selected && active) else $error("selected device not active");
   busy_active_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && !busy && s2_r[SY_CS] |=> !active) else $error("standby not entered when idle");
   unarmed_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
      !armed |-> !rx_valid && !frame_end) else $error("byte reported before arming");
   whole_bytes_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && cs_rise |=> frame_ok == !$past(s2_r[SY_PART])) else $error("frame byte check wrong");
   fast_level_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && s2_r[SY_WPS] ##1 ce |-> fast_mode) else $error("fast mode not following supply");
   page_count_a: assert property (@(posedge clk) disable iff (!resetn)
      data_cnt <= DATA_CNT_MAX) else $error("data count above one page");
   bit_clear_a: assert property (@(posedge sclk) disable iff (!resetn)
      cs_n |-> bit_cnt_r == BIT_FIRST) else $error("bit counter kept across deselect");
   bit_wrap_a: assert property (@(posedge sclk) disable iff (!resetn || cs_n)
      hold_n && bit_cnt_r == BIT_LAST |=> bit_cnt_r == BIT_FIRST) else $error("byte length not eight");

endmodule

/* File: src/sfspi_pkg.sv */
package sfspi_pkg;

   // ----------------------------------------------------------------
   // serial framing
   // ----------------------------------------------------------------
   localparam int BYTE_W = 8;
   localparam int BITCNT_W = 3;
   localparam logic [BITCNT_W-1:0] BIT_FIRST = 3'h0;
   localparam logic [BITCNT_W-1:0] BIT_LAST = 3'h7;
   localparam logic [BITCNT_W-1:0] BIT_STEP = 3'h1;

   // ----------------------------------------------------------------
   // memory geometry: sectors of pages of bytes, linear address
   // ----------------------------------------------------------------
   localparam int SECTORS = 128;
   localparam int PAGES_PER_SECTOR = 256;
   localparam int PAGE_BYTES = 256;
   localparam int SECTOR_W = $clog2(SECTORS);
   localparam int PAGE_W = $clog2(PAGES_PER_SECTOR);
   localparam int OFFS_W = $clog2(PAGE_BYTES);
   localparam int ADDR_W = SECTOR_W + PAGE_W + OFFS_W;
   localparam int DATA_CNT_W = OFFS_W + 1;
   localparam logic [DATA_CNT_W-1:0] DATA_CNT_MAX = 9'h100;
   localparam logic [DATA_CNT_W-1:0] DATA_CNT_ONE = 9'h001;
   localparam logic [DATA_CNT_W-1:0] DATA_CNT_ZERO = 9'h000;
   localparam int ADDR_CNT_W = 2;
   localparam logic [ADDR_CNT_W-1:0] ADDR_CNT_LAST = 2'h2;
   localparam logic [ADDR_CNT_W-1:0] ADDR_CNT_ONE = 2'h1;

   // ----------------------------------------------------------------
   // pin and link synchroniser lanes into the system clock domain
   // ----------------------------------------------------------------
   localparam int NSYNC = 5;
   localparam int SY_CS = 0;
   localparam int SY_HOLD = 1;
   localparam int SY_WPS = 2;
   localparam int SY_TGL = 3;
   localparam int SY_PART = 4;
   // select reads as low during reset so a select held low at power-up is no falling edge
   localparam logic [NSYNC-1:0] SYNC_RST = 5'h02;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_CMD = 2'b01,
      PH_ADDR = 2'b10,
      PH_DATA = 2'b11
   } sfspi_phase_t;

   typedef struct packed {
      logic [SECTOR_W-1:0] sector;
      logic [PAGE_W-1:0] page;
      logic [OFFS_W-1:0] offset;
   } sfspi_addr_t;

   typedef struct packed {
      logic [BYTE_W-1:0] data;
      logic first;
   } sfspi_rx_t;

endpackage

/* File: dv/sfspi_master.sv */
module sfspi_master (
   output logic sclk,
   output logic cs_n,
   output logic hold_n,
   output logic sdi,
   input wire logic sdo_line
);
   timeunit 1ns;
   timeprecision 100ps;

   logic m3;

   // idle bus: deselected, clock low, no pause
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      hold_n = 1'b1;
      sdi = 1'b0;
      m3 = 1'b0;
   end

   // ----------------------------------------------------------------
   // frame control
   // ----------------------------------------------------------------
   // clock parks at the mode's idle level before select falls
   task automatic start(input logic mode3);
      m3 = mode3;
      sclk = mode3;
      #20;
      cs_n = 1'b0;
      #10;
   endtask

   // clock back to idle, then deselect; the released data line flips
   task automatic stop();
      #6;
      sclk = m3;
      #10;
      cs_n = 1'b1;
      sdi = ~sdi;
   endtask

   // ----------------------------------------------------------------
   // bit and byte transfer, 12 ns link clock
   // ----------------------------------------------------------------
   // drive on the fall, both sides sample on the rise
   task automatic bit_x(input logic b, output logic q);
      #6;
      sclk = 1'b0;
      sdi = b;
      #6;
      sclk = 1'b1;
      q = sdo_line;
   endtask

   // msb first; a pause with a running clock and noise on data at bit hold_at
   task automatic byte_x(input logic [7:0] b, input int hold_at, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         if (i == hold_at) begin
            #3;
            hold_n = 1'b0;
            repeat (32) begin
               #6;
               sclk = ~sclk;
               sdi = 1'($urandom);
            end
            #3;
            hold_n = 1'b1;
         end
         bit_x(b[i], q[i]);
      end
   endtask

   // stray clocks that do not make a whole byte
   task automatic bits(input int n);
      logic d;
      repeat (n) bit_x(1'($urandom), d);
   endtask
endmodule

/* File: dv/serial_flash_spi_front_end_bench.sv */
module serial_flash_spi_front_end_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import sfspi_pkg::*;

   logic clk = 1'b0;
   logic resetn, ce, busy, write_protect_supply, tx_valid;
   logic [BYTE_W-1:0] tx_data;
   logic sclk, cs_n, hold_n, sdi, sdo, sdo_oe, tx_ready, rx_valid;
   logic frame_start, frame_end, frame_ok, selected, active, paused, fast_mode, armed;
   sfspi_rx_t rx;
   sfspi_addr_t addr;
   logic [DATA_CNT_W-1:0] data_cnt;
   sfspi_phase_t phase;
   wire sdo_line = sdo_oe ? sdo : 1'bz;
   int err_count = 0;
   int n_checks = 0;
   int n_start = 0;
   int n_end = 0;
   logic [8:0] exp_q[$];

   always #12.5 clk = ~clk;

   sfspi_front_end uut (.clk(clk), .resetn(resetn), .ce(ce), .sclk(sclk), .cs_n(cs_n),
      .hold_n(hold_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
      .write_protect_supply(write_protect_supply), .busy(busy), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx(rx), .rx_valid(rx_valid),
      .frame_start(frame_start), .frame_end(frame_end), .frame_ok(frame_ok), .addr(addr),
      .data_cnt(data_cnt), .phase(phase), .selected(selected), .active(active),
      .paused(paused), .fast_mode(fast_mode), .armed(armed));

   sfspi_master m (.sclk(sclk), .cs_n(cs_n), .hold_n(hold_n), .sdi(sdi), .sdo_line(sdo_line));

   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // each received byte is matched against the oldest note
   always @(negedge clk) begin
      if (rx_valid === 1'b1) begin
         if (exp_q.size() == 0) chk("rx extra", 32'h0, 32'h1);
         else chk("rx", exp_q.pop_front(), rx);
      end
   end

   // frame boundary pulses, counted for the closing check
   always @(negedge clk) begin
      if (frame_start === 1'b1) n_start++;
      if (frame_end === 1'b1) n_end++;
   end

   // watchdog against a hang
   initial begin
      #200000;
      err_count++;
      complete_run();
   end

   // ----------------------------------------------------------------
   // stimulus helpers
   // ----------------------------------------------------------------
   task automatic settle();
      repeat (8) @(negedge clk);
   endtask

   // status sampled in the middle of a pause
   task automatic hold_mon(input int h);
      if (h >= 0) begin
         #200;
         chk("paused", 1, paused);
         chk("sdo_oe", 0, sdo_oe);
      end
   endtask

   // instruction, three address bytes, nd data bytes, extra stray clocks
   task automatic frame(input logic m3, input int nd, input int extra, input int hold_at);
      logic [7:0] q, b, tx;
      logic [23:0] a;
      a = 24'($urandom);
      tx = 8'($urandom);
      @(negedge clk);
      m.start(m3);
      @(negedge clk);
      tx_data = tx;
      tx_valid = 1'b1;
      @(negedge clk);
      tx_valid = 1'b0;
      chk("tx_ready taken", 0, tx_ready);
      for (int k = 0; k < nd + 4; k++) begin
         b = (k == 0 || k > 3) ? 8'($urandom) : a[8*(3-k)+:8];
         exp_q.push_back({b, k == 0});
         fork
            m.byte_x(b, k == 1 ? hold_at : -1, q);
            hold_mon(k == 1 ? hold_at : -1);
         join
         if (k == 1 || (k == 0 && m3)) chk("sdo byte", tx, q);
      end
      m.bits(extra);
      m.stop();
      settle();
      chk("sdo_oe idle", 0, sdo_oe);
      chk("tx_ready idle", 1, tx_ready);
      chk("addr", a[22:0], addr);
      chk("data_cnt", nd > 256 ? 256 : nd, data_cnt);
      chk("frame_ok", extra == 0, frame_ok);
      chk("phase", PH_IDLE, phase);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      busy = 1'b0;
      write_protect_supply = 1'b0;
      tx_data = 8'h00;
      tx_valid = 1'b0;
      void'($urandom(44831));
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      settle();
      chk("armed early", 0, armed);
      m.start(1'b0);
      for (int i = 0; i < 20 && armed !== 1'b1; i++) @(negedge clk);
      chk("armed", 1, armed);
      chk("selected", 1, selected);
      chk("active", 1, active);
      busy = 1'b1;
      m.stop();
      settle();
      chk("selected off", 0, selected);
      chk("active busy", 1, active);
      busy = 1'b0;
      write_protect_supply = 1'b1;
      ce = 1'b0;
      settle();
      chk("active frozen", 1, active);
      chk("fast_mode frozen", 0, fast_mode);
      ce = 1'b1;
      settle();
      chk("standby", 0, active);
      chk("fast_mode", 1, fast_mode);
      write_protect_supply = 1'b0;
      settle();
      chk("fast_mode off", 0, fast_mode);
      frame(1'b0, 1 + int'($urandom % 4), 0, -1);
      frame(1'b0, 1, 0, 4);
      frame(1'b1, 2, 0, -1);
      frame(1'b0, 257, 0, -1);
      frame(1'b0, 1, 5, -1);
      frame(1'b0, 0, 0, -1);
      chk("frame_start", 7, n_start);
      chk("frame_end", 7, n_end);
      chk("rx left", 0, exp_q.size());
      complete_run();
   end
endmodule
